// [core/pmd_pkg.sv]
// Constants for the program memory map decoder.
// Assumes a 16-bit data bus and 20-bit program addresses.
package pmd_pkg;
	// ==========================================
	// Widths
	localparam int PMD_DW   = 16;
	localparam int PMD_PAW  = 20;
	localparam int PMD_RAMW = 13;
	localparam int PMD_ROMW = 12;
	// ==========================================
	// Register map
	localparam logic [15:0] PMD_PAGE_OFS   = 16'h001E;
	localparam logic [15:0] PMD_MODE_OFS   = 16'h001D;
	localparam logic [15:0] PMD_PAGE_RST   = 16'h0000;
	localparam logic [8:0]  PMD_VPTR_RST   = 9'h1FF;
	localparam int          PMD_MODE_RAM_OVERLAY_BIT  = 5;
	localparam int          PMD_MODE_VPLO  = 7;
	// ==========================================
	// Address ranges
	localparam logic [15:0] PMD_RAM_LO     = 16'h0080;
	localparam logic [15:0] PMD_RAM_HI     = 16'h3FFF;
	localparam logic [15:0] PMD_ROM_LO     = 16'hF000;
	localparam logic [15:0] PMD_TEST_LO    = 16'hFF00;
	localparam logic [15:0] PMD_TEST_HI    = 16'hFF7F;
	localparam logic [15:0] PMD_BOOT_VEC   = 16'hFF80;
	// ==========================================
	// Program-flow requests from the core
	typedef enum logic [2:0] {
		PMD_OP_NONE    = 3'h0,
		PMD_OP_FAR_IMM = 3'h1,
		PMD_OP_FAR_ACC = 3'h2,
		PMD_OP_FAR_RET = 3'h3,
		PMD_OP_VECTOR  = 3'h4
	} pmd_op_t;
	// ==========================================
	// Source of a program-bus access
	typedef enum logic [1:0] {
		PMD_SRC_NONE = 2'h0,
		PMD_SRC_RAM  = 2'h1,
		PMD_SRC_ROM  = 2'h3,
		PMD_SRC_EXT  = 2'h2
	} pmd_src_t;
endpackage

// [core/pmd_decoder.sv]
// Program memory map decoder: dual-access RAM, mask ROM, vector table,
// program page register and 20-bit program address forming.
// Assumes the core issues at most one program and one data access a cycle.
`timescale 1ns/100ps
module pmd_decoder #(
	parameter int RAM_WORDS = 8192,
	parameter int ROM_WORDS = 4096
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     srst,
	// Strap
	input  wire logic                     boot_source_select_pin,
	// Register port
	input  wire logic [15:0]              reg_addr,
	input  wire logic [pmd_pkg::PMD_DW-1:0] reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic [pmd_pkg::PMD_DW-1:0]    reg_rdata,
	// Program flow from the core
	input  wire pmd_pkg::pmd_op_t         flow_op,
	input  wire logic [19:0]              flow_target,
	input  wire logic [4:0]               vector_num,
	output logic [15:0]                   pc_load,
	output logic                          pc_load_vld,
	// Program bus
	input  wire logic                     prog_rd,
	input  wire logic                     prog_wr,
	input  wire logic                     prog_far,
	input  wire logic [19:0]              prog_far_addr,
	input  wire logic [15:0]              prog_addr,
	input  wire logic [pmd_pkg::PMD_DW-1:0] prog_wdata,
	output logic [pmd_pkg::PMD_DW-1:0]    prog_rdata,
	output logic                          prog_rvld,
	output logic [pmd_pkg::PMD_PAW-1:0]   ext_prog_addr,
	output logic                          ext_prog_rd,
	output logic                          ext_prog_wr,
	output logic [pmd_pkg::PMD_DW-1:0]    ext_prog_wdata,
	// Data bus
	input  wire logic                     data_rd,
	input  wire logic                     data_wr,
	input  wire logic [15:0]              data_addr,
	input  wire logic [pmd_pkg::PMD_DW-1:0] data_wdata,
	output logic [pmd_pkg::PMD_DW-1:0]    data_rdata,
	output logic                          data_rvld,
	output logic                          data_hit
);
	import pmd_pkg::*;

	// ==========================================
	// Registers
	logic [3:0]        page_r;
	logic [8:0]        vptr_r;
	logic              ram_overlay_bit_r;
	logic              boot_ext_r;
	logic              boot_pending_r;

	// ==========================================
	// Mask ROM; the RAM blocks live in their own instances
	logic [PMD_DW-1:0] rom  [ROM_WORDS];

	// Content is loaded at mask time; the test words stay zero here
	initial begin
		for (int i = 0; i < ROM_WORDS; i++) begin
			rom[i] = 16'h0000;
		end
	end

	// ==========================================
	// Program address forming
	logic [19:0]       p_full;
	logic [15:0]       p_low;
	logic              p_ram;
	logic              p_rom;
	logic              d_ram;
	logic              d_reg;

	always_comb begin
		// Far accesses take all 20 bits, others stay in the page
		if (prog_far) begin
			p_full = prog_far_addr;
		end else begin
			p_full = {page_r, prog_addr};
		end
		p_low = p_full[15:0];
	end

	// Words 0x0080 to 0x3FFF of any page are RAM only with overlay set
	assign p_ram = ram_overlay_bit_r && (p_low >= PMD_RAM_LO)
		&& (p_low <= PMD_RAM_HI);
	// ROM lives in page 0 only; strap high sends it off chip
	assign p_rom = !boot_ext_r && (p_full[19:16] == 4'h0)
		&& (p_low >= PMD_ROM_LO);
	assign d_ram = (data_addr >= PMD_RAM_LO)
		&& (data_addr <= PMD_RAM_HI);
	assign d_reg = (data_addr == PMD_PAGE_OFS)
		|| (data_addr == PMD_MODE_OFS);

	// ==========================================
	// Strap capture and reset sequencing
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boot_ext_r     <= boot_source_select_pin;
			boot_pending_r <= 1'b1;
		end else begin
			boot_pending_r <= 1'b0;
		end
	end

	// ==========================================
	// Vector pointer and overlay bit
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			vptr_r <= PMD_VPTR_RST;
			ram_overlay_bit_r <= 1'b0;
		end else if (reg_wr && reg_addr == PMD_MODE_OFS) begin
			vptr_r <= reg_wdata[15:PMD_MODE_VPLO];
			ram_overlay_bit_r <= reg_wdata[PMD_MODE_RAM_OVERLAY_BIT];
		end
	end

	// ==========================================
	// Page register
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			page_r <= PMD_PAGE_RST[3:0];
		end else if (reg_wr && reg_addr == PMD_PAGE_OFS) begin
			page_r <= reg_wdata[3:0];
		end else begin
			case (flow_op)
				PMD_OP_FAR_IMM,
				PMD_OP_FAR_ACC,
				PMD_OP_FAR_RET: begin
					page_r <= flow_target[19:16];
				end
				default: begin
					page_r <= page_r;
				end
			endcase
		end
	end

	// ==========================================
	// Program counter loads
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pc_load     <= 16'h0000;
			pc_load_vld <= 1'b0;
		end else if (boot_pending_r) begin
			// Reset vector ignores the pointer contents
			pc_load     <= PMD_BOOT_VEC;
			pc_load_vld <= 1'b1;
		end else begin
			case (flow_op)
				PMD_OP_VECTOR: begin
					pc_load     <= {vptr_r, vector_num, 2'b00};
					pc_load_vld <= 1'b1;
				end
				PMD_OP_FAR_IMM,
				PMD_OP_FAR_ACC,
				PMD_OP_FAR_RET: begin
					pc_load     <= flow_target[15:0];
					pc_load_vld <= 1'b1;
				end
				default: begin
					pc_load_vld <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// RAM blocks: the program port and the data port may hit the same
	// block in one cycle; a write plus a read or two reads are served
	logic [PMD_DW-1:0] p_q0;
	logic [PMD_DW-1:0] p_q1;
	logic [PMD_DW-1:0] d_q0;
	logic [PMD_DW-1:0] d_q1;
	logic              p_blk;
	logic              d_blk;

	assign p_blk = p_low[PMD_RAMW];
	assign d_blk = data_addr[PMD_RAMW];

	pmd_ram_blk #(
		.WORDS   (RAM_WORDS),
		.AW      (PMD_RAMW),
		.DW      (PMD_DW)
	) u_pmd_ram_blk_0 (
		.sys_clk (sys_clk),
		.p_we    (prog_wr && p_ram && !p_blk),
		.p_addr  (p_low[PMD_RAMW-1:0]),
		.p_wdata (prog_wdata),
		.p_rdata (p_q0),
		.d_we    (data_wr && d_ram && !d_blk),
		.d_addr  (data_addr[PMD_RAMW-1:0]),
		.d_wdata (data_wdata),
		.d_rdata (d_q0)
	);

	pmd_ram_blk #(
		.WORDS   (RAM_WORDS),
		.AW      (PMD_RAMW),
		.DW      (PMD_DW)
	) u_pmd_ram_blk_1 (
		.sys_clk (sys_clk),
		.p_we    (prog_wr && p_ram && p_blk),
		.p_addr  (p_low[PMD_RAMW-1:0]),
		.p_wdata (prog_wdata),
		.p_rdata (p_q1),
		.d_we    (data_wr && d_ram && d_blk),
		.d_addr  (data_addr[PMD_RAMW-1:0]),
		.d_wdata (data_wdata),
		.d_rdata (d_q1)
	);

	// ==========================================
	// Program read return; off-chip space reads back zero here
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prog_rdata <= 16'h0000;
		end else if (prog_rd && p_ram) begin
			prog_rdata <= p_blk ? p_q1 : p_q0;
		end else if (prog_rd && p_rom) begin
			prog_rdata <= rom[p_low[PMD_ROMW-1:0]];
		end else begin
			prog_rdata <= 16'h0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prog_rvld <= 1'b0;
		end else begin
			prog_rvld <= prog_rd && (p_ram || p_rom);
		end
	end

	// ==========================================
	// External program bus; ROM writes are dropped
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ext_prog_addr  <= 20'h00000;
			ext_prog_rd    <= 1'b0;
			ext_prog_wr    <= 1'b0;
			ext_prog_wdata <= 16'h0000;
		end else begin
			ext_prog_addr  <= p_full;
			ext_prog_rd    <= prog_rd && !p_ram && !p_rom;
			ext_prog_wr    <= prog_wr && !p_ram && !p_rom;
			ext_prog_wdata <= prog_wdata;
		end
	end

	// ==========================================
	// Data side: RAM and register read-back
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			data_rvld  <= 1'b0;
			data_hit   <= 1'b0;
		end else begin
			data_rvld  <= data_rd && d_ram;
			data_hit   <= (data_rd || data_wr) && (d_ram || d_reg);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			data_rdata <= 16'h0000;
		end else if (data_rd && d_ram) begin
			data_rdata <= d_blk ? d_q1 : d_q0;
		end else begin
			data_rdata <= 16'h0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				PMD_PAGE_OFS: reg_rdata <= {12'h000, page_r};
				PMD_MODE_OFS: reg_rdata <= {vptr_r, 1'b0, ram_overlay_bit_r, 5'h00};
				default:      reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule

// ==========================================
// One dual-access RAM block with a program port and a data port
module pmd_ram_blk #(
	parameter int WORDS = 8192,
	parameter int AW    = 13,
	parameter int DW    = 16
) (
	// Clock
	input  wire logic          sys_clk,
	// Program port
	input  wire logic          p_we,
	input  wire logic [AW-1:0] p_addr,
	input  wire logic [DW-1:0] p_wdata,
	output logic      [DW-1:0] p_rdata,
	// Data port
	input  wire logic          d_we,
	input  wire logic [AW-1:0] d_addr,
	input  wire logic [DW-1:0] d_wdata,
	output logic      [DW-1:0] d_rdata
);
	logic [DW-1:0] mem [WORDS];

	// A clash keeps the program write; the data write is lost
	always_ff @(posedge sys_clk) begin
		if (p_we) begin
			mem[p_addr] <= p_wdata;
		end else if (d_we) begin
			mem[d_addr] <= d_wdata;
		end
	end

	// Two read ports, registered by the owner so outputs stay flops
	assign p_rdata = mem[p_addr];
	assign d_rdata = mem[d_addr];
endmodule

// [test/pmd_ext_mem.sv]
// Model of external program memory beside the decoder.
// Assumes one clock shared with the decoder.
`timescale 1ns/100ps
module pmd_ext_mem (
	// Clock
	input  wire logic        sys_clk,
	// External program bus
	input  wire logic [19:0] ext_prog_addr,
	input  wire logic        ext_prog_wr,
	input  wire logic [15:0] ext_prog_wdata,
	// Last write seen
	output logic      [19:0] mem_addr,
	output logic      [15:0] mem_data
);
	// ==========================================
	// Capture
	always_ff @(posedge sys_clk) begin
		if (ext_prog_wr) begin
			mem_addr <= ext_prog_addr;
			mem_data <= ext_prog_wdata;
		end
	end
endmodule

// [test/pmd_decoder_sva.sv]
// Port assertions for the decoder.
// Assumes a single clock domain and synchronous reset.
`timescale 1ns/100ps
module pmd_decoder_sva (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              srst,
	// Watched ports
	input  wire logic              boot_source_select_pin,
	input  wire logic              reg_rd,
	input  wire logic [15:0]       reg_rdata,
	input  wire pmd_pkg::pmd_op_t  flow_op,
	input  wire logic [19:0]       flow_target,
	input  wire logic [4:0]        vector_num,
	input  wire logic [15:0]       pc_load,
	input  wire logic              pc_load_vld,
	input  wire logic              prog_rd,
	input  wire logic              prog_far,
	input  wire logic [19:0]       prog_far_addr,
	input  wire logic              prog_rvld,
	input  wire logic              ext_prog_rd,
	input  wire logic [19:0]       ext_prog_addr,
	input  wire logic              data_rd,
	input  wire logic              data_wr,
	input  wire logic [15:0]       data_addr,
	input  wire logic              data_rvld,
	input  wire logic              data_hit
);
	import pmd_pkg::*;
	// ==========================================
	// Helpers
	logic up_r;
	logic strap_r;
	// Low in the first cycle after release, when ops are overridden
	always_ff @(posedge sys_clk) begin
		up_r <= !srst;
	end
	// Strap as latched under reset; later pin moves do not count
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			strap_r <= boot_source_select_pin;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence rel_s;
		srst ##1 !srst;
	endsequence
	sequence far_s;
		up_r && flow_op inside {PMD_OP_FAR_IMM, PMD_OP_FAR_ACC,
			PMD_OP_FAR_RET};
	endsequence
	// ==========================================
	// Assertions
	reset_vector_a: assert property (disable iff (1'b0)
		rel_s |=> pc_load_vld && pc_load == PMD_BOOT_VEC)
		else $error("reset vector not loaded");
	vector_slot_a: assert property (
		up_r && flow_op == PMD_OP_VECTOR |=> pc_load_vld
		&& pc_load[6:0] == {$past(vector_num), 2'b00})
		else $error("vector slot offset wrong");
	far_target_a: assert property (
		far_s |=> pc_load_vld
		&& {4'h0, pc_load} == ($past(flow_target) & 20'h0FFFF))
		else $error("far target not loaded");
	no_load_a: assert property (
		up_r && flow_op == PMD_OP_NONE |=> !pc_load_vld)
		else $error("spurious pc load");
	ram_hit_a: assert property (
		data_rd && data_addr >= PMD_RAM_LO && data_addr <= PMD_RAM_HI
		|=> data_hit && data_rvld)
		else $error("data ram read missed");
	ram_miss_a: assert property (
		(data_rd || data_wr) && data_addr[15:14] != 2'b00 |=> !data_hit)
		else $error("data hit outside ram");
	rom_route_a: assert property (
		prog_rd && prog_far && prog_far_addr[19:12] == 8'h0F
		|=> ext_prog_rd == strap_r
		&& prog_rvld != strap_r)
		else $error("rom range routed wrongly");
	far_ext_a: assert property (
		prog_rd && prog_far && prog_far_addr[19:16] != 4'h0
		&& prog_far_addr[15:14] != 2'b00
		|=> ext_prog_rd && ext_prog_addr == $past(prog_far_addr))
		else $error("far access address wrong");
	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not idle");
endmodule
bind pmd_decoder pmd_decoder_sva u_pmd_decoder_sva (.*);

// [test/pmd_decoder_tb_top.sv]
// Self-checking bench for the decoder with external memory model.
// Assumes the checker is bound to the decoder.
`timescale 1ns/100ps
module pmd_decoder_tb_top;
	import pmd_pkg::*;
	logic        sys_clk = 1'h0, srst = 1'h1;
	logic        boot_source_select_pin = 1'h0;
	logic        reg_wr = 1'h0, reg_rd = 1'h0, prog_rd = 1'h0;
	logic        prog_wr = 1'h0, prog_far = 1'h0;
	logic        data_rd = 1'h0, data_wr = 1'h0;
	logic [15:0] reg_addr = '0, reg_wdata = '0, prog_addr = '0;
	logic [15:0] prog_wdata = '0, data_addr = '0, data_wdata = '0;
	logic [19:0] flow_target = '0, prog_far_addr = '0;
	logic [4:0]  vector_num = '0;
	pmd_op_t     flow_op = PMD_OP_NONE;
	logic [15:0] reg_rdata, pc_load, prog_rdata, ext_prog_wdata;
	logic [15:0] data_rdata, mem_data, v;
	logic [19:0] ext_prog_addr, mem_addr;
	logic        pc_load_vld, prog_rvld, ext_prog_rd, ext_prog_wr;
	logic        data_rvld, data_hit;
	int          num_errors = 0, total_checks = 0;
	pmd_decoder u_pmd_decoder (.*);
	pmd_ext_mem u_pmd_ext_mem (.*);
	always #25 sys_clk = ~sys_clk;
	// ==========================================
	// Tasks
	task chk(string n, logic [19:0] got, logic [19:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask
	task complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task do_reset(logic pin);
		@(posedge sys_clk);
		srst <= 1'h1;
		boot_source_select_pin <= pin;
		repeat (6) @(posedge sys_clk);
		srst <= 1'h0;
		@(posedge sys_clk);
		#1;
		chk("rst_vec", {3'h0, pc_load_vld, pc_load}, 20'h1FF80);
	endtask
	task wr(logic [15:0] a, logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task rd(logic [15:0] a, logic [15:0] e, string n);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1;
		chk(n, reg_rdata, e);
	endtask
	task fl(pmd_op_t op, logic [19:0] t, logic [4:0] n, logic [15:0] e);
		@(posedge sys_clk);
		flow_op <= op;
		flow_target <= t;
		vector_num <= n;
		@(posedge sys_clk);
		flow_op <= PMD_OP_NONE;
		#1;
		chk("pc", {3'h0, pc_load_vld, pc_load}, {4'h1, e});
	endtask
	task pg(logic w, logic f, logic [19:0] a, logic [15:0] d);
		@(posedge sys_clk);
		prog_rd <= !w;
		prog_wr <= w;
		prog_far <= f;
		prog_far_addr <= a;
		prog_addr <= a[15:0];
		prog_wdata <= d;
		@(posedge sys_clk);
		prog_rd <= 1'h0;
		prog_wr <= 1'h0;
		#1;
	endtask
	task dt(logic w, logic [15:0] a, logic [15:0] d);
		@(posedge sys_clk);
		data_rd <= !w;
		data_wr <= w;
		data_addr <= a;
		data_wdata <= d;
		@(posedge sys_clk);
		data_rd <= 1'h0;
		data_wr <= 1'h0;
		#1;
	endtask
	// ==========================================
	// Tests
	initial begin
		do_reset(1'h0);
		rd(PMD_PAGE_OFS, 16'h0000, "page_rst");
		rd(PMD_MODE_OFS, 16'hFF80, "mode_rst");
		rd(16'h0040, 16'h0000, "unmapped");
		wr(PMD_PAGE_OFS, 16'hFFFF);
		rd(PMD_PAGE_OFS, 16'h000F, "page_wr");
		fl(PMD_OP_VECTOR, 20'h0, 5'd2, 16'hFF88);
		wr(PMD_MODE_OFS, 16'h0100);
		fl(PMD_OP_VECTOR, 20'h0, 5'd31, 16'h017C);
		for (int i = 1; i < 4; i++) begin
			fl(pmd_op_t'(3'(i)), {i[3:0], 16'h1234}, 5'd0, 16'h1234);
			rd(PMD_PAGE_OFS, 16'(i), "far_page");
		end
		fl(PMD_OP_VECTOR, 20'h0, 5'd1, 16'h0104);
		rd(PMD_PAGE_OFS, 16'h0003, "page_kept");
		pg(1'h0, 1'h0, 20'h00100, 16'h0000);
		chk("ext_addr", ext_prog_addr, 20'h30100);
		wr(PMD_MODE_OFS, 16'h0120);
		dt(1'h1, 16'h0100, 16'hA5A5);
		dt(1'h1, 16'h2100, 16'h5A5A);
		pg(1'h0, 1'h0, 20'h00100, 16'h0000);
		chk("ram_overlay_bit", {ext_prog_rd, prog_rvld, prog_rdata}, 20'h1A5A5);
		dt(1'h0, 16'h0100, 16'h0000);
		chk("blk0", {data_hit, data_rvld, data_rdata}, 20'h3A5A5);
		dt(1'h0, 16'h2100, 16'h0000);
		chk("blk1", {data_hit, data_rvld, data_rdata}, 20'h35A5A);
		dt(1'h0, 16'h4000, 16'h0000);
		chk("miss", data_hit, 20'h0);
		pg(1'h0, 1'h1, 20'h0F010, 16'h0000);
		v = prog_rdata;
		chk("rom", {ext_prog_rd, prog_rvld}, 20'h1);
		pg(1'h1, 1'h1, 20'h0F010, ~v);
		chk("rom_drop", ext_prog_wr, 20'h0);
		pg(1'h0, 1'h1, 20'h0F010, 16'h0000);
		chk("rom_wr", prog_rdata, v);
		pg(1'h1, 1'h1, 20'h58000, 16'h1234);
		@(posedge sys_clk);
		#1;
		chk("twr", {mem_addr[3:0], mem_data}, 20'h01234);
		chk("twr_a", mem_addr, 20'h58000);
		do_reset(1'h1);
		rd(PMD_PAGE_OFS, 16'h0000, "page_rst2");
		pg(1'h0, 1'h1, 20'h0F000, 16'h0000);
		chk("boot_ext", {ext_prog_rd, prog_rvld}, 20'h2);
		complete_run();
	end
	// Bound well above the roughly 80 cycles the tests need
	initial begin
		repeat (3000) @(posedge sys_clk);
		num_errors++;
		complete_run();
	end
endmodule
